// ---- src/shared_enable_latches.sv ----
`timescale 1ns/1ns
`default_nettype none

// How it works
// - An open drive latch passes the bus straight to the driver enables.
// - A high drive enable bit turns its driver on, a low bit powers it down.
// - A closing drive latch holds the last bus value the host kept valid.
// - A low sampled device reset clears the drive latch, both drivers off.
// - An open self-test latch passes the bus to the self-test selects.
// - A low self-test bit selects test pattern, a high bit normal traffic.
// - A closing self-test latch holds the last bus value.
// - A low sampled device reset clears a closed self-test latch to normal.
// - An open receive power latch passes bus bit 0 to receive power.
// - A high receive power enable runs the receive side, low saves power.
// - A closing receive power latch holds the last value of bus bit 0.
// - A low sampled device reset clears a closed receive power latch.
// - The active low link fault output shows any of four receive faults.
// - Device reset is sampled on the clock edge and resets the sequencer.
module shared_enable_latches
  import enable_latch_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset,
  input  wire logic       device_reset_n,
  input  wire logic       drive_enable_latch_open,
  input  wire logic       selftest_latch_open,
  input  wire logic       rx_power_latch_open,
  input  wire logic [1:0] shared_enable_bus,
  input  wire logic       rx_freq_out_of_range,
  input  wire logic       rx_amplitude_low,
  input  wire logic       rx_density_low,
  output var  logic [1:0] serial_out_pair_en,
  output var  logic       tx_normal_mode,
  output var  logic       rx_normal_mode,
  output var  logic       rx_power_en,
  output var  logic       link_fault_n,
  output var  logic       link_ready
);

  // ==========================================================================
  // pin synchroniser
  // every pin is asynchronous; the whole group moves through the same two
  // stages so the bus and the latch controls keep their relative timing
  pin_sample_type pins_raw;
  pin_sample_type pins_meta_q;
  pin_sample_type pins_q;

  assign pins_raw = '{
    dev_rst_n : device_reset_n,
    drv_open  : drive_enable_latch_open,
    st_open   : selftest_latch_open,
    rx_open   : rx_power_latch_open,
    bus       : shared_enable_bus,
    freq_bad  : rx_freq_out_of_range,
    amp_low   : rx_amplitude_low,
    dens_low  : rx_density_low
  };

  // first stage is read only by the second stage
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      pins_meta_q <= '0;
      pins_q      <= '0;
    end
    else
    begin
      pins_meta_q <= pins_raw;
      pins_q      <= pins_meta_q;
    end
  end

  // ==========================================================================
  // device reset sampling
  // the synchroniser resets to zero, so the device counts as held in reset
  // until the pin has been seen high through both stages
  logic dev_clear;

  assign dev_clear = !pins_q.dev_rst_n;

  // ==========================================================================
  // mapped bus slices
  logic [1:0] drive_data;
  logic [1:0] selftest_data;
  logic [0:0] rx_power_data;

  assign drive_data    = pick2(pins_q.bus, DRIVE1_BIT, DRIVE0_BIT);
  assign selftest_data = pick2(pins_q.bus, TX_SELFTEST_BIT,
                               RX_SELFTEST_BIT);
  assign rx_power_data = pins_q.bus[RX_POWER_BIT];

  // ==========================================================================
  // drive enable latch
  // the clear wins even while open: a reset must never leave a driver on
  logic [1:0] drive_q;

  enable_latch #(
    .WIDTH     (2),
    .RESET_VAL (DRIVE_RESET_VAL),
    .OPEN_WINS (1'b0)
  ) u_drive_latch (
    .core_clk   (core_clk),
    .reset      (reset),
    .latch_open (pins_q.drv_open),
    .latch_data (drive_data),
    .clear_req  (dev_clear),
    .latch_q    (drive_q)
  );

  // high bit powers the driver, low bit powers it down
  assign serial_out_pair_en = drive_q;

  // ==========================================================================
  // self-test latch
  // only a closed latch is cleared, an open one keeps following the bus
  logic [1:0] selftest_q;

  enable_latch #(
    .WIDTH     (2),
    .RESET_VAL (SELFTEST_RESET_VAL),
    .OPEN_WINS (1'b1)
  ) u_selftest_latch (
    .core_clk   (core_clk),
    .reset      (reset),
    .latch_open (pins_q.st_open),
    .latch_data (selftest_data),
    .clear_req  (dev_clear),
    .latch_q    (selftest_q)
  );

  // low selects test pattern, high selects normal traffic
  assign tx_normal_mode = selftest_q[1];
  assign rx_normal_mode = selftest_q[0];

  // ==========================================================================
  // receive power latch
  logic [0:0] rx_power_q;

  enable_latch #(
    .WIDTH     (1),
    .RESET_VAL (RX_POWER_RESET_VAL),
    .OPEN_WINS (1'b1)
  ) u_rx_power_latch (
    .core_clk   (core_clk),
    .reset      (reset),
    .latch_open (pins_q.rx_open),
    .latch_data (rx_power_data),
    .clear_req  (dev_clear),
    .latch_q    (rx_power_q)
  );

  assign rx_power_en = rx_power_q[0];

  // ==========================================================================
  // reset sequencer
  // status is not trusted until a fixed settle time after reset release
  seq_state_type seq_q;
  seq_state_type seq_d;
  logic [3:0]    settle_cnt_q;

  always_comb
  begin
    seq_d = seq_q;
    case (seq_q)
      SEQ_RESET:
      begin
        if (!dev_clear)
        begin
          seq_d = SEQ_SETTLE;
        end
      end
      SEQ_SETTLE:
      begin
        if (dev_clear)
        begin
          seq_d = SEQ_RESET;
        end
        else if (settle_cnt_q == SETTLE_CYCLES)
        begin
          seq_d = SEQ_RUN;
        end
      end
      SEQ_RUN:
      begin
        if (dev_clear)
        begin
          seq_d = SEQ_RESET;
        end
      end
      default:
      begin
        seq_d = SEQ_RESET;
      end
    endcase
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      seq_q <= SEQ_RESET;
    end
    else
    begin
      seq_q <= seq_d;
    end
  end

  // settle counter runs only in the settle state
  always_ff @(posedge core_clk)
  begin
    if (reset || seq_q != SEQ_SETTLE)
    begin
      settle_cnt_q <= 4'h1;
    end
    else
    begin
      settle_cnt_q <= settle_cnt_q + 4'h1;
    end
  end

  // ==========================================================================
  // link fault indication
  // a powered-down receiver is itself a fault; while settling the output
  // also shows a fault so the host never sees a premature good link
  logic fault_any;

  assign fault_any = pins_q.freq_bad | pins_q.amp_low | pins_q.dens_low
                   | !rx_power_q[0];

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      link_fault_n <= 1'b0;
      link_ready   <= 1'b0;
    end
    else
    begin
      link_fault_n <= !(fault_any || seq_d != SEQ_RUN);
      link_ready   <= (seq_d == SEQ_RUN);
    end
  end

  // ==========================================================================
  // assertions
  AST_DRIVE_PASS: assert property (@(posedge core_clk) disable iff (reset)
    pins_q.drv_open && !dev_clear |=>
      serial_out_pair_en == pick2($past(pins_q.bus), DRIVE1_BIT, DRIVE0_BIT))
    else $error("drive latch did not follow the bus while open");

  AST_DRIVE_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    !pins_q.drv_open && !dev_clear |=> $stable(serial_out_pair_en))
    else $error("drive latch changed while closed");

  AST_DRIVE_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    dev_clear |=> serial_out_pair_en == 2'h0)
    else $error("device reset left a driver enabled");

  AST_DRIVER_ON: assert property (@(posedge core_clk) disable iff (reset)
    pins_q.drv_open && !dev_clear && pins_q.bus[DRIVE0_BIT] |=>
      serial_out_pair_en[0])
    else $error("high enable bit did not turn the driver on");

  AST_SELFTEST_PASS: assert property (@(posedge core_clk) disable iff (reset)
    pins_q.st_open |=> {tx_normal_mode, rx_normal_mode} ==
      pick2($past(pins_q.bus), TX_SELFTEST_BIT, RX_SELFTEST_BIT))
    else $error("self-test latch did not follow the bus while open");

  AST_SELFTEST_LOW: assert property (@(posedge core_clk) disable iff (reset)
    pins_q.st_open && !pins_q.bus[TX_SELFTEST_BIT] |=> !tx_normal_mode)
    else $error("low bit did not select transmit self-test");

  AST_SELFTEST_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    !pins_q.st_open && !dev_clear |=>
      $stable({tx_normal_mode, rx_normal_mode}))
    else $error("self-test latch changed while closed");

  AST_SELFTEST_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    !pins_q.st_open && dev_clear |=>
      {tx_normal_mode, rx_normal_mode} == SELFTEST_RESET_VAL)
    else $error("closed self-test latch not cleared by reset");

  AST_RXPWR_PASS: assert property (@(posedge core_clk) disable iff (reset)
    pins_q.rx_open |=> rx_power_en == $past(pins_q.bus[RX_POWER_BIT]))
    else $error("receive power latch did not follow bit 0");

  AST_RXPWR_HOLD: assert property (@(posedge core_clk) disable iff (reset)
    !pins_q.rx_open && !dev_clear |=> $stable(rx_power_en))
    else $error("receive power latch changed while closed");

  AST_RXPWR_CLEAR: assert property (@(posedge core_clk) disable iff (reset)
    !pins_q.rx_open && dev_clear |=> !rx_power_en)
    else $error("closed receive power latch not cleared by reset");

  AST_RX_OFF_FAULT: assert property (@(posedge core_clk) disable iff (reset)
    !rx_power_en |=> !link_fault_n)
    else $error("powered down receiver did not flag a fault");

  AST_FAULT_ANY: assert property (@(posedge core_clk) disable iff (reset)
    fault_any |=> !link_fault_n)
    else $error("fault condition not shown on link fault output");

  AST_FAULT_CLEAN: assert property (@(posedge core_clk) disable iff (reset)
    !link_fault_n ##0 $past(seq_q) == SEQ_RUN ##0 seq_q == SEQ_RUN |->
      $past(fault_any))
    else $error("link fault shown with no cause");

  AST_SEQ_SETTLE: assert property (@(posedge core_clk) disable iff (reset)
    $fell(dev_clear) |=> !link_ready [*8] ##8 link_ready)
    else $error("settle time after device reset is wrong");

  AST_SEQ_RESET: assert property (@(posedge core_clk) disable iff (reset)
    dev_clear |=> seq_q == SEQ_RESET && !link_ready)
    else $error("sequencer not held in reset");

  COV_DRIVE_CAPTURE: cover property (@(posedge core_clk) disable iff (reset)
    $fell(pins_q.drv_open) ##1 serial_out_pair_en == 2'h3);

  COV_SELFTEST_BOTH: cover property (@(posedge core_clk) disable iff (reset)
    !tx_normal_mode && !rx_normal_mode);

  COV_LINK_UP: cover property (@(posedge core_clk) disable iff (reset)
    rx_power_en && link_fault_n);

  COV_OPEN_RESET: cover property (@(posedge core_clk) disable iff (reset)
    pins_q.rx_open && dev_clear && pins_q.bus[RX_POWER_BIT]);

endmodule

`default_nettype wire

// ---- src/enable_latch_pkg.sv ----
package enable_latch_pkg;

  // ==========================================================================
  // bit mapping of the shared enable bus (fixed at build time)
  localparam int unsigned DRIVE0_BIT     = 0;  // serial_out_pair[0] enable
  localparam int unsigned DRIVE1_BIT     = 1;  // serial_out_pair[1] enable
  localparam int unsigned TX_SELFTEST_BIT = 1; // transmit self-test select
  localparam int unsigned RX_SELFTEST_BIT = 0; // receive self-test select
  localparam int unsigned RX_POWER_BIT   = 0;  // receive pll/analog power

  // ==========================================================================
  // values after reset
  localparam logic [1:0] DRIVE_RESET_VAL    = 2'h0; // both drivers off
  localparam logic [1:0] SELFTEST_RESET_VAL = 2'h3; // high = normal traffic
  localparam logic [0:0] RX_POWER_RESET_VAL = 1'h0; // receive side off

  // ==========================================================================
  // the sequencer stays this many cycles in the settle state after device reset release
  localparam logic [3:0] SETTLE_CYCLES = 4'hf;

  // ==========================================================================
  // sequencer states
  typedef enum logic [1:0] {
    SEQ_RESET  = 2'b00,
    SEQ_SETTLE = 2'b01,
    SEQ_RUN    = 2'b10
  } seq_state_type;

  // ==========================================================================
  // asynchronous pin group, carried through the synchroniser together
  typedef struct packed {
    logic       dev_rst_n;
    logic       drv_open;
    logic       st_open;
    logic       rx_open;
    logic [1:0] bus;
    logic       freq_bad;
    logic       amp_low;
    logic       dens_low;
  } pin_sample_type;

  // picks two mapped bits out of the enable bus, high bit first
  function automatic logic [1:0] pick2(input logic [1:0] bus,
                                       input int unsigned hi,
                                       input int unsigned lo);
    pick2 = {bus[hi], bus[lo]};
  endfunction

endpackage

// ---- src/enable_latch.sv ----
`timescale 1ns/1ns
`default_nettype none

// level latch modelled on the core clock: follows the data while open,
// holds while closed, and is cleared on request
module enable_latch
  import enable_latch_pkg::*;
#(
  parameter int unsigned      WIDTH     = 2,
  parameter logic [WIDTH-1:0] RESET_VAL = '0,
  parameter bit               OPEN_WINS = 1'b0
)(
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic             latch_open,
  input  wire logic [WIDTH-1:0] latch_data,
  input  wire logic             clear_req,
  output var  logic [WIDTH-1:0] latch_q
);

  // ==========================================================================
  // storage
  // an open latch may be told to ignore the clear, so a host that is
  // actively configuring it is not overridden
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      latch_q <= RESET_VAL;
    end
    else if (clear_req && !(OPEN_WINS && latch_open))
    begin
      latch_q <= RESET_VAL;
    end
    else if (latch_open)
    begin
      latch_q <= latch_data;  // transparent phase
    end
  end

endmodule

`default_nettype wire

// ---- dv/host_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// host side: drives latch controls, shared enable bus and receive conditions
module host_model
(
  input  wire logic       core_clk,
  output var  logic       device_reset_n,
  output var  logic       drive_open,
  output var  logic       st_open,
  output var  logic       rx_open,
  output var  logic [1:0] bus,
  output var  logic [2:0] rx_cond
);
  // device held in reset, all latches closed until told otherwise
  initial
  begin
    device_reset_n = 1'b0;
    drive_open     = 1'b0;
    st_open        = 1'b0;
    rx_open        = 1'b0;
    bus            = 2'h0;
    rx_cond        = 3'h0;
  end

  // bus settles before any latch may close on it, which covers the lag
  task automatic put_bus(input logic [1:0] b, input logic [2:0] c);
    @(posedge core_clk);
    #1;
    bus     = b;
    rx_cond = c;
    repeat (4) @(posedge core_clk);
  endtask

  // lone bus change, used to time the latch lag
  task automatic set_bus(input logic [1:0] b);
    bus = b;
  endtask

  // controls move 1 ns after a clock edge; bus stays put after a close
  task automatic put_ctrl(input logic [2:0] o, input logic r);
    @(posedge core_clk);
    #1;
    {drive_open, st_open, rx_open} = o;
    device_reset_n                 = r;
    repeat (4) @(posedge core_clk);
  endtask
endmodule

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ns
`default_nettype none

// ============================================================================
// top of bench: host model, design and a reference model with integers
module tb
  import enable_latch_pkg::*;
;
  logic       core_clk;
  logic       reset;
  logic       device_reset_n;
  logic       drive_open;
  logic       st_open;
  logic       rx_open;
  logic [1:0] bus;
  logic [2:0] rx_cond;
  logic [1:0] serial_out_pair_en;
  logic       tx_normal_mode;
  logic       rx_normal_mode;
  logic       rx_power_en;
  logic       link_fault_n;
  logic       link_ready;
  int         bad_count;
  int         num_checks;
  int         cycles;
  int         seed;
  int         m_drv;
  int         m_st;
  int         m_rx;
  int         m_ready;

  host_model h (
    .core_clk       (core_clk),
    .device_reset_n (device_reset_n),
    .drive_open     (drive_open),
    .st_open        (st_open),
    .rx_open        (rx_open),
    .bus            (bus),
    .rx_cond        (rx_cond)
  );

  shared_enable_latches i_dut (
    .core_clk                (core_clk),
    .reset                   (reset),
    .device_reset_n          (device_reset_n),
    .drive_enable_latch_open (drive_open),
    .selftest_latch_open     (st_open),
    .rx_power_latch_open     (rx_open),
    .shared_enable_bus       (bus),
    .rx_freq_out_of_range    (rx_cond[2]),
    .rx_amplitude_low        (rx_cond[1]),
    .rx_density_low          (rx_cond[0]),
    .serial_out_pair_en      (serial_out_pair_en),
    .tx_normal_mode          (tx_normal_mode),
    .rx_normal_mode          (rx_normal_mode),
    .rx_power_en             (rx_power_en),
    .link_fault_n            (link_fault_n),
    .link_ready              (link_ready)
  );

  // ==========================================================================
  // clock and hang guard; a run of tests needs well under 5000 cycles
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      bad_count = bad_count + 1;
      end_sim();
    end
  end

  // ==========================================================================
  // checking helpers
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string nm, input logic [1:0] exp,
                       input logic [1:0] got);
    num_checks = num_checks + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  // bus value as it lands on the two driver enables
  function automatic logic [1:0] drv_map(input int v);
    drv_map = {v[DRIVE1_BIT], v[DRIVE0_BIT]};
  endfunction

  task automatic compare_all(input logic [2:0] c);
    logic fault;
    #1; // look past the edge that launched the outputs
    fault = (c != 3'h0) || (m_rx == 0);
    check("drive_en", drv_map(m_drv), serial_out_pair_en);
    check("tx_normal", m_st[TX_SELFTEST_BIT], tx_normal_mode);
    check("rx_normal", m_st[RX_SELFTEST_BIT], rx_normal_mode);
    check("rx_power", m_rx[0], rx_power_en);
    check("link_fault_n", !fault && m_ready != 0, link_fault_n);
    check("link_ready", m_ready[0], link_ready);
  endtask

  // bus first, controls next; a latch open in either phase takes the bus, unless device reset clears it: the drive latch always, the others once closed
  task automatic step(input logic [1:0] b, input logic [2:0] c,
                      input logic [2:0] o, input logic r);
    logic [2:0] was;
    was = {drive_open, st_open, rx_open};
    h.put_bus(b, c);
    h.put_ctrl(o, r);
    repeat (20) @(posedge core_clk); // sequencer settles within this
    if (!r)
      m_drv = 0;
    else if (o[2] || (was[2] && m_ready != 0)) // cleared while in reset
      m_drv = b;
    if (o[1])
      m_st = b;
    else if (!r)
      m_st = SELFTEST_RESET_VAL;
    else if (was[1])
      m_st = b;
    if (o[0])
      m_rx = b[RX_POWER_BIT];
    else if (!r)
      m_rx = RX_POWER_RESET_VAL;
    else if (was[0])
      m_rx = b[RX_POWER_BIT];
    m_ready = r;
    compare_all(c);
  endtask

  // ==========================================================================
  // main sequence
  initial
  begin
    reset      = 1'b1;
    bad_count  = 0;
    num_checks = 0;
    cycles     = 0;
    seed       = 32'hd3b2;
    m_drv      = DRIVE_RESET_VAL;
    m_st       = SELFTEST_RESET_VAL;
    m_rx       = RX_POWER_RESET_VAL;
    m_ready    = 0;
    repeat (16) @(posedge core_clk);
    #1;
    reset = 1'b0;
    repeat (3) @(posedge core_clk);
    compare_all(3'h0);
    $display("test reset_values done");

    // release with receive side off: fault shown for a disabled channel
    step(2'h0, 3'h0, 3'b000, 1'b1);
    for (int i = 0; i < 4; i++)
      step(2'h1, (i == 0) ? 3'h0 : 3'(1 << (i - 1)), 3'b001, 1'b1);
    $display("test fault_sources done");

    // drive latch open: bus change appears on the third edge
    step(2'h1, 3'h0, 3'b100, 1'b1);
    @(posedge core_clk);
    #1;
    h.set_bus(2'h2);
    repeat (2) @(posedge core_clk);
    #1;
    check("drive_lag2", drv_map(1), serial_out_pair_en);
    @(posedge core_clk);
    #1;
    check("drive_lag3", drv_map(2), serial_out_pair_en);
    m_drv = 2;
    $display("test drive_latency done");

    // close all on 11, then the bus goes to 00 and must be ignored
    step(2'h3, 3'h0, 3'b111, 1'b1);
    step(2'h3, 3'h0, 3'b000, 1'b1);
    step(2'h0, 3'h0, 3'b000, 1'b1);
    $display("test hold_after_close done");

    // device reset with latches open, then closing under reset
    step(2'h2, 3'h0, 3'b111, 1'b0);
    step(2'h1, 3'h0, 3'b000, 1'b0);
    step(2'h1, 3'h0, 3'b000, 1'b1);
    $display("test device_reset done");

    // random mix of bus, conditions, latch controls and device reset
    for (int n = 0; n < 40; n++)
      step(2'($random(seed)), 3'($random(seed)), 3'($random(seed)),
           ($random(seed) & 7) != 0);
    $display("test random_mix done");
    end_sim();
  end
endmodule

`default_nettype wire
